// >>> hdl/lpcc_pkg.sv
// constants shared by the low-power counter/compare block
package lpcc_pkg;

   // ==========================================================
   // widths
   localparam int COUNT_W  = 24;
   localparam int PRESCALE_DOWN_COUNT_W  = 12;
   localparam int CHANNELS = 4;
   localparam int EVENTS   = 6;
   localparam int ADDR_W   = 12;

   // ==========================================================
   // register byte offsets
   localparam logic [11:0] ADDR_TASK_START = 12'h000;
   localparam logic [11:0] ADDR_TASK_STOP  = 12'h004;
   localparam logic [11:0] ADDR_TASK_CLEAR = 12'h008;
   localparam logic [11:0] ADDR_TASK_WRAP  = 12'h00C;
   localparam logic [11:0] ADDR_EV_TICK    = 12'h100;
   localparam logic [11:0] ADDR_EV_WRAP    = 12'h104;
   localparam logic [11:0] ADDR_EV_CMP0    = 12'h140;
   localparam logic [11:0] ADDR_ROUTE      = 12'h340;
   localparam logic [11:0] ADDR_ROUTE_SET  = 12'h344;
   localparam logic [11:0] ADDR_ROUTE_CLR  = 12'h348;
   localparam logic [11:0] ADDR_STATUS     = 12'h400;
   localparam logic [11:0] ADDR_COUNTER    = 12'h504;
   localparam logic [11:0] ADDR_PRESCALER  = 12'h508;
   localparam logic [11:0] ADDR_CMP0       = 12'h540;

   // ==========================================================
   // field positions
   localparam int ROUTE_TICK_BIT = 0;
   localparam int ROUTE_WRAP_BIT = 1;
   localparam int ROUTE_CMP_LSB  = 16;
   localparam int EV_TICK_IDX    = 0;
   localparam int EV_WRAP_IDX    = 1;
   localparam int EV_CMP_LSB     = 2;
   localparam int TASK_START     = 0;
   localparam int TASK_STOP      = 1;
   localparam int TASK_CLEAR     = 2;
   localparam int TASK_WRAP      = 3;

   // ==========================================================
   // reset values and fixed values
   localparam logic [23:0] COUNTER_RST     = 24'h000000;
   localparam logic [23:0] COUNTER_MAX     = 24'hFFFFFF;
   localparam logic [23:0] NEAR_WRAP_VALUE = 24'hFFFFF0;
   localparam logic [11:0] PRESCALER_RST   = 12'h000;
   localparam logic [11:0] DOWN_COUNT_ZERO = 12'h000;
   localparam logic [23:0] COMPARE_RST     = 24'h000000;
   localparam logic [31:0] ROUTE_RST       = 32'h00000000;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ==========================================================
   // timing
   localparam int          SLOW_CLOCK_HZ     = 32768;
   localparam logic [1:0]  READ_STALL_CYCLES = 2'h3;

endpackage

// >>> hdl/lpcc_counter_compare.sv
// low-power 24-bit counter with prescaler, compare channels and AXI4-Lite registers
//
// Contract
// - 24-bit counter fed by 12-bit prescaler
// - increment rate is slow clock over prescaler+1
// - prescaler writable only while counter is stopped
// - start, clear, near-wrap reload the down-count
// - increment when down-count is zero, then reload
// - tick event per increment, disabled after reset
// - near-wrap task loads 0xFFFFF0
// - wrap event on 0xFFFFFF to zero, off at reset
// - disabled events request no fast clock
// - clearing never fires a zero compare
// - start at matching count gives no compare
// - compare fires only on step into value
// - compare at count plus two always fires
// - old compare over two ahead never fires
// - counter captured on read; tasks synchronised
// - tasks act after slow falling then rising edge
// - first increment follows start by prescaler+1 slow periods
// - near-wrap task requests the slow clock
// - compare spacing jitter within 62.5 ns
// - counter read stalls three extra cycles
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps

module lpcc_counter_compare (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        slowClockIn,
   output logic             slowClockStartReq,
   output logic             fastClockReq,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // ==========================================================
   // types and state
   typedef enum logic [1:0] {WR_IDLE, WR_ACCEPT, WR_RESP} lpcc_wr_state_t;
   typedef enum logic [1:0] {RD_IDLE, RD_ACCEPT, RD_STALL, RD_RESP} lpcc_rd_state_t;

   lpcc_wr_state_t wrState_reg;
   lpcc_rd_state_t rdState_reg;
   logic [1:0]     stallCount_reg;

   logic        slowSync1_reg;
   logic        slowSync2_reg;
   logic        slowPrev_reg;
   logic        slowRise;
   logic        slowFall;

   logic [3:0]  taskPend_reg;
   logic [3:0]  taskArmed_reg;
   logic [3:0]  taskReq;
   logic [3:0]  taskDone;
   logic [3:0]  taskPend_next;

   logic [23:0] counter_reg;
   logic [11:0] prescale_down_count_reg;
   logic [11:0] prescaler_reg;
   logic        running_reg;
   logic        increment;
   logic        reload;
   logic [23:0] counterPlusOne;

   logic [23:0] compare_value_reg [lpcc_pkg::CHANNELS];
   logic [31:0] event_route_enable_reg;
   logic [5:0]  eventFlags_reg;
   logic [5:0]  eventHits;
   logic [5:0]  eventSet;
   logic [5:0]  eventClr;
   logic [5:0]  eventFlags_next;

   logic        wrFire;
   logic [11:0] wrAddr;
   logic [11:0] rdAddr;
   logic [31:0] rdData_next;
   logic        rdMapped;
   logic [31:0] prescMerged;
   logic [31:0] cmpMerged;

   // ==========================================================
   // helpers
   function automatic logic [31:0] strobeMerge(input logic [31:0] oldVal,
                                               input logic [31:0] newVal,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = oldVal;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = newVal[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // four consecutive words starting at base
   function automatic logic inSlotGroup(input logic [11:0] addr,
                                        input logic [11:0] base);
      return addr[11:4] == base[11:4];
   endfunction

   function automatic logic isMapped(input logic [11:0] addr);
      return addr[11:4] == lpcc_pkg::ADDR_TASK_START[11:4]
         || addr == lpcc_pkg::ADDR_EV_TICK
         || addr == lpcc_pkg::ADDR_EV_WRAP
         || inSlotGroup(addr, lpcc_pkg::ADDR_EV_CMP0)
         || addr == lpcc_pkg::ADDR_ROUTE
         || addr == lpcc_pkg::ADDR_ROUTE_SET
         || addr == lpcc_pkg::ADDR_ROUTE_CLR
         || addr == lpcc_pkg::ADDR_STATUS
         || addr == lpcc_pkg::ADDR_COUNTER
         || addr == lpcc_pkg::ADDR_PRESCALER
         || inSlotGroup(addr, lpcc_pkg::ADDR_CMP0);
   endfunction

   // route register layout folded onto the event flag order
   function automatic logic [5:0] routeToEvents(input logic [31:0] route);
      return {route[lpcc_pkg::ROUTE_CMP_LSB +: 4],
              route[lpcc_pkg::ROUTE_WRAP_BIT],
              route[lpcc_pkg::ROUTE_TICK_BIT]};
   endfunction

   // ==========================================================
   // write channel: address and data taken together
   assign wrAddr = s_axi_awaddr[11:0];
   assign wrFire = wrState_reg == WR_ACCEPT;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wrState_reg   <= WR_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= lpcc_pkg::RESP_OKAY;
      end else begin
         case (wrState_reg)
            WR_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid) begin
                  s_axi_awready <= 1'b1;
                  s_axi_wready  <= 1'b1;
                  wrState_reg   <= WR_ACCEPT;
               end
            end
            WR_ACCEPT: begin
               s_axi_awready <= 1'b0;
               s_axi_wready  <= 1'b0;
               s_axi_bvalid  <= 1'b1;
               s_axi_bresp   <= isMapped(wrAddr) ? lpcc_pkg::RESP_OKAY
                                                 : lpcc_pkg::RESP_SLVERR;
               wrState_reg   <= WR_RESP;
            end
            default: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wrState_reg  <= WR_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // read channel; a counter read is held back so a slow edge
   // during the access cannot tear the sampled value
   assign rdAddr = s_axi_araddr[11:0];

   always_comb begin
      rdData_next = 32'h00000000;
      rdMapped    = isMapped(rdAddr);
      if (rdAddr == lpcc_pkg::ADDR_EV_TICK) begin
         rdData_next[0] = eventFlags_reg[lpcc_pkg::EV_TICK_IDX];
      end else if (rdAddr == lpcc_pkg::ADDR_EV_WRAP) begin
         rdData_next[0] = eventFlags_reg[lpcc_pkg::EV_WRAP_IDX];
      end else if (inSlotGroup(rdAddr, lpcc_pkg::ADDR_EV_CMP0)) begin
         rdData_next[0] = eventFlags_reg[lpcc_pkg::EV_CMP_LSB + int'(rdAddr[3:2])];
      end else if (rdAddr == lpcc_pkg::ADDR_ROUTE
                   || rdAddr == lpcc_pkg::ADDR_ROUTE_SET
                   || rdAddr == lpcc_pkg::ADDR_ROUTE_CLR) begin
         rdData_next = event_route_enable_reg;
      end else if (rdAddr == lpcc_pkg::ADDR_STATUS) begin
         rdData_next[4:0] = {taskPend_reg, running_reg};
      end else if (rdAddr == lpcc_pkg::ADDR_COUNTER) begin
         rdData_next[23:0] = counter_reg;
      end else if (rdAddr == lpcc_pkg::ADDR_PRESCALER) begin
         rdData_next[11:0] = prescaler_reg;
      end else if (inSlotGroup(rdAddr, lpcc_pkg::ADDR_CMP0)) begin
         rdData_next[23:0] = compare_value_reg[rdAddr[3:2]];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdState_reg    <= RD_IDLE;
         stallCount_reg <= 2'h0;
         s_axi_arready  <= 1'b0;
         s_axi_rvalid   <= 1'b0;
         s_axi_rdata    <= 32'h00000000;
         s_axi_rresp    <= lpcc_pkg::RESP_OKAY;
      end else begin
         case (rdState_reg)
            RD_IDLE: begin
               if (s_axi_arvalid) begin
                  s_axi_arready <= 1'b1;
                  rdState_reg   <= RD_ACCEPT;
               end
            end
            RD_ACCEPT: begin
               s_axi_arready <= 1'b0;
               s_axi_rdata   <= rdData_next;
               s_axi_rresp   <= rdMapped ? lpcc_pkg::RESP_OKAY : lpcc_pkg::RESP_SLVERR;
               if (rdAddr == lpcc_pkg::ADDR_COUNTER) begin
                  stallCount_reg <= lpcc_pkg::READ_STALL_CYCLES;
                  rdState_reg    <= RD_STALL;
               end else begin
                  s_axi_rvalid <= 1'b1;
                  rdState_reg  <= RD_RESP;
               end
            end
            RD_STALL: begin
               stallCount_reg <= stallCount_reg - 2'h1;
               if (stallCount_reg == 2'h1) begin
                  s_axi_rvalid <= 1'b1;
                  rdState_reg  <= RD_RESP;
               end
            end
            default: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rdState_reg  <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // slow clock sampling; the first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         slowSync1_reg <= 1'b0;
         slowSync2_reg <= 1'b0;
         slowPrev_reg  <= 1'b0;
      end else begin
         slowSync1_reg <= slowClockIn;
         slowSync2_reg <= slowSync1_reg;
         slowPrev_reg  <= slowSync2_reg;
      end
   end

   assign slowRise = slowSync2_reg && !slowPrev_reg;
   assign slowFall = !slowSync2_reg && slowPrev_reg;

   // ==========================================================
   // tasks: pending until a slow falling edge arms them, done on
   // the following rising edge
   always_comb begin
      taskReq = 4'h0;
      if (wrFire && wrAddr[11:4] == lpcc_pkg::ADDR_TASK_START[11:4]
          && s_axi_wstrb[0] && s_axi_wdata[0]) begin
         taskReq[wrAddr[3:2]] = 1'b1;
      end
   end

   assign taskDone      = taskArmed_reg & {4{slowRise}};
   assign taskPend_next = (taskPend_reg & ~taskDone) | taskReq;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         taskPend_reg  <= 4'h0;
         taskArmed_reg <= 4'h0;
      end else begin
         taskPend_reg  <= taskPend_next;
         taskArmed_reg <= (taskArmed_reg | (taskPend_reg & {4{slowFall}})) & ~taskDone;
      end
   end

   // near-wrap load waits for the slow clock, so ask for it to run
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         slowClockStartReq <= 1'b0;
      end else begin
         slowClockStartReq <= taskPend_next[lpcc_pkg::TASK_WRAP];
      end
   end

   // ==========================================================
   // counter and prescaler, acting only on slow rising edges
   assign reload = taskDone[lpcc_pkg::TASK_START] || taskDone[lpcc_pkg::TASK_CLEAR]
                || taskDone[lpcc_pkg::TASK_WRAP];
   assign increment = slowRise && running_reg && !taskDone[lpcc_pkg::TASK_CLEAR]
                   && !taskDone[lpcc_pkg::TASK_WRAP]
                   && prescale_down_count_reg == lpcc_pkg::DOWN_COUNT_ZERO;
   assign counterPlusOne = counter_reg + 24'h000001;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         counter_reg <= lpcc_pkg::COUNTER_RST;
      end else if (taskDone[lpcc_pkg::TASK_CLEAR]) begin
         counter_reg <= lpcc_pkg::COUNTER_RST;
      end else if (taskDone[lpcc_pkg::TASK_WRAP]) begin
         counter_reg <= lpcc_pkg::NEAR_WRAP_VALUE;
      end else if (increment) begin
         counter_reg <= counterPlusOne;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prescale_down_count_reg <= lpcc_pkg::PRESCALER_RST;
      end else if (reload || increment) begin
         prescale_down_count_reg <= prescaler_reg;
      end else if (slowRise && running_reg) begin
         prescale_down_count_reg <= prescale_down_count_reg - 12'h001;
      end
   end

   // stop wins over a start that lands on the same edge
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         running_reg <= 1'b0;
      end else if (taskDone[lpcc_pkg::TASK_STOP]) begin
         running_reg <= 1'b0;
      end else if (taskDone[lpcc_pkg::TASK_START]) begin
         running_reg <= 1'b1;
      end
   end

   // ==========================================================
   // configuration registers; merged words are named so their low bits can be taken
   assign prescMerged = strobeMerge({20'h00000, prescaler_reg}, s_axi_wdata, s_axi_wstrb);
   assign cmpMerged   = strobeMerge({8'h00, compare_value_reg[wrAddr[3:2]]}, s_axi_wdata,
                                    s_axi_wstrb);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prescaler_reg <= lpcc_pkg::PRESCALER_RST;
      end else if (wrFire && wrAddr == lpcc_pkg::ADDR_PRESCALER
                   && !running_reg && !taskPend_reg[lpcc_pkg::TASK_START]) begin
         prescaler_reg <= prescMerged[11:0];
      end
   end

   // a new compare value takes effect at once, so an old value
   // more than two counts ahead can no longer be reached
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int c = 0; c < lpcc_pkg::CHANNELS; c++) begin
            compare_value_reg[c] <= lpcc_pkg::COMPARE_RST;
         end
      end else if (wrFire && inSlotGroup(wrAddr, lpcc_pkg::ADDR_CMP0)) begin
         compare_value_reg[wrAddr[3:2]] <= cmpMerged[23:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         event_route_enable_reg <= lpcc_pkg::ROUTE_RST;
      end else if (wrFire && wrAddr == lpcc_pkg::ADDR_ROUTE) begin
         event_route_enable_reg <= strobeMerge(event_route_enable_reg, s_axi_wdata,
                                               s_axi_wstrb);
      end else if (wrFire && wrAddr == lpcc_pkg::ADDR_ROUTE_SET) begin
         event_route_enable_reg <= event_route_enable_reg
                                 | strobeMerge(32'h00000000, s_axi_wdata, s_axi_wstrb);
      end else if (wrFire && wrAddr == lpcc_pkg::ADDR_ROUTE_CLR) begin
         event_route_enable_reg <= event_route_enable_reg
                                 & ~strobeMerge(32'h00000000, s_axi_wdata, s_axi_wstrb);
      end
   end

   // ==========================================================
   // events: compares look at the value being stepped into, so a
   // clear, a load or a start never counts as a match
   always_comb begin
      eventHits = 6'h00;
      eventHits[lpcc_pkg::EV_TICK_IDX] = increment;
      eventHits[lpcc_pkg::EV_WRAP_IDX] = increment
                                      && counter_reg == lpcc_pkg::COUNTER_MAX;
      for (int c = 0; c < lpcc_pkg::CHANNELS; c++) begin
         eventHits[lpcc_pkg::EV_CMP_LSB + c] = increment
            && counterPlusOne == compare_value_reg[c];
      end
   end

   always_comb begin
      eventClr = 6'h00;
      if (wrFire && s_axi_wstrb[0] && !s_axi_wdata[0]) begin
         if (wrAddr == lpcc_pkg::ADDR_EV_TICK) begin
            eventClr[lpcc_pkg::EV_TICK_IDX] = 1'b1;
         end else if (wrAddr == lpcc_pkg::ADDR_EV_WRAP) begin
            eventClr[lpcc_pkg::EV_WRAP_IDX] = 1'b1;
         end else if (inSlotGroup(wrAddr, lpcc_pkg::ADDR_EV_CMP0)) begin
            eventClr[lpcc_pkg::EV_CMP_LSB + int'(wrAddr[3:2])] = 1'b1;
         end
      end
   end

   // set wins over a clear in the same cycle
   assign eventSet        = eventHits & routeToEvents(event_route_enable_reg);
   assign eventFlags_next = (eventFlags_reg & ~eventClr) | eventSet;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         eventFlags_reg <= 6'h00;
      end else begin
         eventFlags_reg <= eventFlags_next;
      end
   end

   // only routed events reach the fast clock request
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         fastClockReq <= 1'b0;
      end else begin
         fastClockReq <= |eventFlags_next;
      end
   end

endmodule

// >>> verif/lpcc_checker.sv
// bus handshake and reset checks for the counter/compare block
`timescale 1ns/1ps
module lpcc_checker (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        fastClockReq,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ==========================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready held more than one cycle");
   arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready held more than one cycle");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid)
      else $error("write response late");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid stayed after bready");
   rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid stayed after rready");
   read_fast_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[11:0] != lpcc_pkg::ADDR_COUNTER |=> s_axi_rvalid)
      else $error("register read late");
   count_stall_a: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr[11:0] == lpcc_pkg::ADDR_COUNTER |=> !s_axi_rvalid [*3] ##1 s_axi_rvalid)
      else $error("counter read not stalled three cycles");
   rst_quiet_a: assert property (disable iff (1'b0)
      sys_rst |=> !s_axi_bvalid && !s_axi_rvalid && !fastClockReq)
      else $error("outputs active after reset");
   // ==========================================
   // covers
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (fastClockReq);
   cover property (s_axi_arready && s_axi_araddr[11:0] == lpcc_pkg::ADDR_COUNTER);
endmodule

bind lpcc_counter_compare lpcc_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .fastClockReq(fastClockReq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> verif/test_low_power_counter_compare.sv
// self-checking bench for the counter/compare block
`timescale 1ns/1ps
module test_low_power_counter_compare;
   logic        sys_clk, sys_rst, slowClockIn, slowRun, slowClockStartReq, fastClockReq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d, n;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int          fails, n_compared, lc, ln;

   lpcc_counter_compare u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .slowClockIn(slowClockIn),
      .slowClockStartReq(slowClockStartReq), .fastClockReq(fastClockReq),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // ==========================================
   // clocks; slow clock sped up to 40 cycles a period, it holds its level while stopped
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      slowClockIn = 1'b0;
      forever begin
         #160;
         if (slowRun) slowClockIn = ~slowClockIn;
      end
   end

   // ==========================================
   // bus tasks; ready lines stay high so they are never driven twice in one step
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         fails++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      s_axi_awaddr <= {20'h00000, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp === lpcc_pkg::RESP_OKAY, "write refused");
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output int lat);
      lat = 0;
      s_axi_araddr <= {20'h00000, a};
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge sys_clk);
         lat++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic slow(input int k);
      repeat (k) @(posedge slowClockIn);
      @(posedge sys_clk);
   endtask

   // ==========================================
   // scenarios
   task automatic t_reset();
      rd(lpcc_pkg::ADDR_COUNTER, d, lc);
      chk(d === 32'h00000000 && r === lpcc_pkg::RESP_OKAY, "counter reset");
      rd(lpcc_pkg::ADDR_PRESCALER, d, ln);
      chk(d === 32'h00000000, "prescaler reset");
      chk(lc - ln == 3, "counter read stall");
      rd(lpcc_pkg::ADDR_ROUTE, d, ln);
      chk(d === lpcc_pkg::ROUTE_RST, "route reset");
      rd(12'h800, d, ln);
      chk(r === lpcc_pkg::RESP_SLVERR && d === 32'h00000000, "unmapped read");
      wr(lpcc_pkg::ADDR_PRESCALER, 32'hFFFFFFFF);
      rd(lpcc_pkg::ADDR_PRESCALER, d, ln);
      chk(d === 32'h00000FFF, "prescaler width");
      wr(lpcc_pkg::ADDR_PRESCALER, 32'h00000001);
   endtask
   task automatic t_tick();
      wr(lpcc_pkg::ADDR_TASK_START, 32'h00000001);
      slow(6);
      rd(lpcc_pkg::ADDR_EV_TICK, d, ln);
      chk(d === 32'h00000000 && fastClockReq === 1'b0, "unrouted tick");
      wr(lpcc_pkg::ADDR_ROUTE_SET, 32'h00000001);
      slow(4);
      rd(lpcc_pkg::ADDR_EV_TICK, d, ln);
      chk(d === 32'h00000001 && fastClockReq === 1'b1, "routed tick");
      wr(lpcc_pkg::ADDR_PRESCALER, 32'h00000000);
      rd(lpcc_pkg::ADDR_PRESCALER, d, ln);
      chk(d === 32'h00000001, "prescaler written while running");
      slow(1);
      rd(lpcc_pkg::ADDR_COUNTER, n, ln);
      slow(8);
      rd(lpcc_pkg::ADDR_COUNTER, d, ln);
      chk(d - n === 32'h00000004, "rate at prescaler one");
      wr(lpcc_pkg::ADDR_ROUTE_CLR, 32'h00000001);
   endtask
   task automatic t_wrap();
      slowRun = 1'b0;
      wr(lpcc_pkg::ADDR_ROUTE_SET, 32'h00000002);
      wr(lpcc_pkg::ADDR_TASK_WRAP, 32'h00000001);
      repeat (4) @(posedge sys_clk);
      chk(slowClockStartReq === 1'b1, "slow clock request");
      slowRun = 1'b1;
      slow(4);
      rd(lpcc_pkg::ADDR_COUNTER, d, ln);
      chk(d[23:4] === 20'hFFFFF, "near wrap load");
      slow(40);
      rd(lpcc_pkg::ADDR_EV_WRAP, d, ln);
      chk(d === 32'h00000001, "wrap event");
      rd(lpcc_pkg::ADDR_COUNTER, d, ln);
      chk(d < 32'h00000010, "count after wrap");
   endtask
   task automatic t_cmp();
      wr(lpcc_pkg::ADDR_ROUTE_SET, 32'h00030000);
      wr(lpcc_pkg::ADDR_TASK_CLEAR, 32'h00000001);
      slow(6);
      rd(lpcc_pkg::ADDR_EV_CMP0, d, ln);
      chk(d === 32'h00000000, "clear fired compare zero");
      rd(lpcc_pkg::ADDR_COUNTER, n, ln);
      wr(lpcc_pkg::ADDR_CMP0 + 12'h004, n + 32'h00000002);
      wr(lpcc_pkg::ADDR_CMP0 + 12'h008, n + 32'h00000002);
      slow(10);
      rd(lpcc_pkg::ADDR_EV_CMP0 + 12'h004, d, ln);
      chk(d === 32'h00000001, "compare at count plus two");
      rd(lpcc_pkg::ADDR_EV_CMP0 + 12'h008, d, ln);
      chk(d === 32'h00000000, "unrouted compare");
      wr(lpcc_pkg::ADDR_TASK_STOP, 32'h00000001);
      slow(3);
      rd(lpcc_pkg::ADDR_COUNTER, n, ln);
      wr(lpcc_pkg::ADDR_CMP0, n);
      slow(4);
      rd(lpcc_pkg::ADDR_COUNTER, d, ln);
      chk(d === n, "stopped counter moved");
      wr(lpcc_pkg::ADDR_TASK_START, 32'h00000001);
      slow(4);
      rd(lpcc_pkg::ADDR_EV_CMP0, d, ln);
      chk(d === 32'h00000000, "start at match fired");
   endtask

   // ==========================================
   // run control
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      finish_test();
   end
   initial begin
      fails = 0;
      n_compared = 0;
      slowRun = 1'b1;
      sys_rst = 1'b1;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (5) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_tick();
      t_wrap();
      t_cmp();
      finish_test();
   end
endmodule
